// File: inc/spbfc_map.vh
`ifndef SPBFC_MAP_VH
`define SPBFC_MAP_VH
// Register offsets within the port window
`define SPBFC_OFF_DIV_HIGH   8'h18
`define SPBFC_OFF_DIV_LOW    8'h19
`define SPBFC_OFF_CTRL_ONE   8'h1A
`define SPBFC_OFF_CTRL_TWO   8'h1B
// Divisor high register fields
`define SPBFC_DH_BREAK_IRQ   7
`define SPBFC_DH_EDGE_IRQ    6
`define SPBFC_DH_DIV_MASK    8'h1F
// Control one fields
`define SPBFC_C1_LOOP        7
`define SPBFC_C1_RXSRC       5
`define SPBFC_C1_NINE        4
`define SPBFC_C1_ILT         2
`define SPBFC_C1_PAR_EN      1
`define SPBFC_C1_PAR_ODD     0
`define SPBFC_C1_MASK        8'hB7
// Control two fields
`define SPBFC_C2_TXE_IRQ     7
`define SPBFC_C2_TXD_IRQ     6
`define SPBFC_C2_RXF_IRQ     5
`define SPBFC_C2_IDLE_IRQ    4
`define SPBFC_C2_TX_ON       3
`define SPBFC_C2_RX_ON       2
`define SPBFC_C2_WAKEUP      1
`define SPBFC_C2_BREAK       0
// Reset values
`define SPBFC_RST_DIV_HIGH   8'h00
`define SPBFC_RST_DIV_LOW    8'h04
`define SPBFC_RST_CTRL_ONE   8'h00
`define SPBFC_RST_CTRL_TWO   8'h00
// Timing: prescale times oversample gives 64 clocks per divisor unit
`define SPBFC_PRESCALE_LAST  2'h3
`define SPBFC_OVS_LAST       4'hF
`define SPBFC_OVS_MID        4'h7
`define SPBFC_TICKS_PER_BIT  8'h10
`endif

// File: rtl/spbfc_top.v
// Function
// - Break-seen flag raises the interrupt when break_irq_en is set.
// - Edge-seen flag raises the interrupt when edge_irq_en is set.
// - Divisor is 13 bits from high[4:0] and low; zero stops the generator.
// - Bit rate is bus clock divided by 64 times the divisor.
// - Loop mode ties transmitter output to receiver; receive pin unused.
// - Without loop mode, separate receive and transmit pins, full duplex.
// - Receiver source select only matters in loop mode.
// - Loop mode with source 0 is purely internal loopback.
// - Loop mode with source 1 is single wire on the transmit pin.
// - Eight-bit frame: start, eight data bits LSB first, stop.
// - Nine-bit frame: start, eight data LSB first, ninth bit, stop.
// - Idle count starts after start bit, or after stop bit when selected.
// - Parity enable generates and checks parity in the top data bit.
// - Parity type 0 is even, 1 is odd, over all ones.
// - Control two is read/write any time, fixed field order, resets zero.
// - High divisor write is buffered until the low half is written.
// - Generator stays stopped after reset until tx_on or rx_on written 1.
`timescale 1ns/100ps
`default_nettype none
`include "spbfc_map.vh"

module spbfc_fifo
#(
  parameter WIDTH = 9,
  parameter DEPTH = 8,
  parameter AW    = 3
)
(
  input  wire             mclk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wptr_q;
  reg  [AW-1:0]    rptr_q;
  reg  [AW:0]      cnt_q;
  reg              room_q;
  wire             push;
  wire             pop;

  assign push      = in_valid & room_q;
  assign pop       = out_ready & (cnt_q != {(AW+1){1'b0}});
  assign in_ready  = room_q;
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rptr_q];

  // Storage has no reset; only pointers need a defined start
  always @(posedge mclk)
  begin
    if (push)
      mem[wptr_q] <= in_data;
  end

  // Pointers wrap at DEPTH; ready has its own flop so the port leaves a register
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wptr_q <= {AW{1'b0}};
      rptr_q <= {AW{1'b0}};
      cnt_q  <= {(AW+1){1'b0}};
      room_q <= 1'b1;
    end
    else
    begin
      if (push)
        wptr_q <= (wptr_q == DEPTH-1) ? {AW{1'b0}} : wptr_q + 1'b1;
      if (pop)
        rptr_q <= (rptr_q == DEPTH-1) ? {AW{1'b0}} : rptr_q + 1'b1;
      if (push & ~pop)
      begin
        cnt_q  <= cnt_q + 1'b1;
        room_q <= (cnt_q != DEPTH-1);
      end
      else if (pop & ~push)
      begin
        cnt_q  <= cnt_q - 1'b1;
        room_q <= 1'b1;
      end
    end
  end
endmodule // spbfc_fifo

module spbfc_top
(
  input  wire       mclk,
  input  wire       rst_n,
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata_q,
  input  wire [8:0] tx_data,
  input  wire       tx_valid,
  output wire       tx_ready,
  output reg  [8:0] rx_data_q,
  output reg        rx_full_q,
  output reg        rx_par_err_q,
  output reg        rx_frame_err_q,
  input  wire       rx_take,
  input  wire [2:0] flag_clr,
  output reg        break_seen_flag_q,
  output reg        edge_seen_flag_q,
  output reg        idle_flag_q,
  output reg        irq_q,
  input  wire       rxd_i,
  input  wire       txd_i,
  output reg        txd_o_q,
  output reg        txd_oe_n_q
);
  localparam T_IDLE = 2'b01;
  localparam T_SEND = 2'b10;
  localparam R_IDLE = 3'b001;
  localparam R_STRT = 3'b010;
  localparam R_DATA = 3'b100;

  reg  [7:0]  div_high_q;
  reg  [4:0]  div_buf_q;
  reg  [7:0]  div_low_q;
  reg  [7:0]  ctrl_one_q;
  reg  [7:0]  ctrl_two_q;
  reg         baud_run_q;
  reg  [12:0] bcnt_q;
  reg  [1:0]  qcnt_q;
  reg         tick_q;
  reg         rxd_s1_q;
  reg         rxd_s2_q;
  reg         txd_s1_q;
  reg         txd_s2_q;
  reg         line_prev_q;
  reg  [1:0]  tst_q;
  reg  [10:0] tsh_q;
  reg  [3:0]  tbits_q;
  reg  [3:0]  ttick_q;
  reg  [2:0]  rst_q;
  reg  [9:0]  rsh_q;
  reg  [3:0]  rbits_q;
  reg  [3:0]  rtick_q;
  reg  [7:0]  hi_cnt_q;
  reg         idle_armed_q;
  wire [12:0] divisor_value;
  wire        gen_on;
  wire        loopback_select;
  wire        rx_source_select;
  wire        nine_bit;
  wire        rx_line;
  wire [3:0]  nbits;
  wire [8:0]  fifo_data;
  wire        fifo_valid;
  wire        fifo_pop;
  wire        frame_end;
  wire [8:0]  rx_word;
  wire        rx_is_break;
  wire        idle_hit;
  wire        wr_low;

  // Build an LSB-first frame; top data bit replaced by parity when enabled
  function [10:0] spbfc_frame;
    input [8:0] d;
    input       nine;
    input       pen;
    input       podd;
    reg   [8:0] w;
    begin
      w = d;
      if (pen & nine)
        w[8] = (^d[7:0]) ^ podd;
      else if (pen)
        w[7] = (^d[6:0]) ^ podd;
      if (nine)
        spbfc_frame = {1'b1, w[8:0], 1'b0};
      else
        spbfc_frame = {2'b11, w[7:0], 1'b0};
    end
  endfunction

  assign divisor_value    = {div_high_q[4:0], div_low_q};
  assign gen_on           = baud_run_q & (divisor_value != 13'h0000);
  assign loopback_select  = ctrl_one_q[`SPBFC_C1_LOOP];
  assign rx_source_select = ctrl_one_q[`SPBFC_C1_RXSRC];
  assign nine_bit         = ctrl_one_q[`SPBFC_C1_NINE];
  assign nbits            = nine_bit ? 4'hA : 4'h9; // Data plus stop after start
  assign wr_low           = reg_wr & (reg_addr == `SPBFC_OFF_DIV_LOW);

  // Receiver input routing; source select only counts in loop mode
  assign rx_line = !loopback_select ? rxd_s2_q :
                   rx_source_select ? txd_s2_q :
                   txd_o_q;

  // Register writes; unused bits masked so they read zero
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      div_high_q <= `SPBFC_RST_DIV_HIGH;
      div_buf_q  <= 5'h00;
      div_low_q  <= `SPBFC_RST_DIV_LOW;
      ctrl_one_q <= `SPBFC_RST_CTRL_ONE;
      ctrl_two_q <= `SPBFC_RST_CTRL_TWO;
      baud_run_q <= 1'b0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `SPBFC_OFF_DIV_HIGH:
        begin
          // Enables take effect now, divisor half waits for low write
          div_high_q[7:6] <= reg_wdata[7:6];
          div_buf_q       <= reg_wdata[4:0];
        end
        `SPBFC_OFF_DIV_LOW:
        begin
          div_low_q       <= reg_wdata;
          div_high_q[4:0] <= div_buf_q;
        end
        `SPBFC_OFF_CTRL_ONE: ctrl_one_q <= reg_wdata & `SPBFC_C1_MASK;
        `SPBFC_OFF_CTRL_TWO:
        begin
          ctrl_two_q <= reg_wdata;
          if (reg_wdata[`SPBFC_C2_TX_ON] | reg_wdata[`SPBFC_C2_RX_ON])
            baud_run_q <= 1'b1;
        end
        default: ctrl_two_q <= ctrl_two_q;
      endcase
    end
  end

  // Register reads, one cycle after the strobe; unmapped reads zero
  always @(posedge mclk)
  begin
    if (!rst_n)
      reg_rdata_q <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `SPBFC_OFF_DIV_HIGH: reg_rdata_q <= {div_high_q[7:6], 1'b0, div_high_q[4:0]};
        `SPBFC_OFF_DIV_LOW:  reg_rdata_q <= div_low_q;
        `SPBFC_OFF_CTRL_ONE: reg_rdata_q <= ctrl_one_q;
        `SPBFC_OFF_CTRL_TWO: reg_rdata_q <= ctrl_two_q;
        default:             reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // Tick at 16x bit rate: divisor times 4 clocks per tick
  always @(posedge mclk)
  begin
    if (!rst_n || !gen_on || wr_low)
    begin
      bcnt_q <= 13'h0000;
      qcnt_q <= 2'h0;
      tick_q <= 1'b0;
    end
    else if (bcnt_q == divisor_value - 13'h0001)
    begin
      bcnt_q <= 13'h0000;
      qcnt_q <= qcnt_q + 2'h1;
      tick_q <= (qcnt_q == `SPBFC_PRESCALE_LAST);
    end
    else
    begin
      bcnt_q <= bcnt_q + 13'h0001;
      tick_q <= 1'b0;
    end
  end

  // Pin synchronisers, two stages each
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
      txd_s1_q <= 1'b1;
      txd_s2_q <= 1'b1;
    end
    else
    begin
      rxd_s1_q <= rxd_i;
      rxd_s2_q <= rxd_s1_q;
      txd_s1_q <= txd_i;
      txd_s2_q <= txd_s1_q;
    end
  end

  // Transmit words queue here so software can run ahead of the line
  spbfc_fifo #(.WIDTH(9), .DEPTH(8), .AW(3)) u_txq
  (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  assign fifo_pop = (tst_q == T_IDLE) & tick_q & ctrl_two_q[`SPBFC_C2_TX_ON] &
                    ~ctrl_two_q[`SPBFC_C2_BREAK];

  // Transmitter; the break bit sends an all-zero frame ahead of queued data
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      tst_q      <= T_IDLE;
      tsh_q      <= 11'h7FF;
      tbits_q    <= 4'h0;
      ttick_q    <= 4'h0;
      txd_o_q    <= 1'b1;
      txd_oe_n_q <= 1'b1;
    end
    else
    begin
      // Pin driven while the transmitter is on or still finishing
      txd_oe_n_q <= ~(ctrl_two_q[`SPBFC_C2_TX_ON] | (tst_q == T_SEND));
      case (tst_q)
        T_IDLE:
        begin
          txd_o_q <= 1'b1;
          if (tick_q && ctrl_two_q[`SPBFC_C2_TX_ON] && ctrl_two_q[`SPBFC_C2_BREAK])
          begin
            tsh_q   <= 11'h000;
            tbits_q <= nbits;
            ttick_q <= 4'h0;
            txd_o_q <= 1'b0;
            tst_q   <= T_SEND;
          end
          else if (fifo_pop && fifo_valid)
          begin
            tsh_q   <= spbfc_frame(fifo_data, nine_bit, ctrl_one_q[`SPBFC_C1_PAR_EN],
                                   ctrl_one_q[`SPBFC_C1_PAR_ODD]);
            tbits_q <= nbits;
            ttick_q <= 4'h0;
            txd_o_q <= 1'b0;
            tst_q   <= T_SEND;
          end
        end
        T_SEND:
        begin
          if (tick_q)
          begin
            ttick_q <= ttick_q + 4'h1;
            if (ttick_q == `SPBFC_OVS_LAST)
            begin
              // Shift next bit out, LSB first
              if (tbits_q == 4'h0)
                tst_q <= T_IDLE;
              else
              begin
                tsh_q   <= {1'b1, tsh_q[10:1]};
                txd_o_q <= tsh_q[1];
                tbits_q <= tbits_q - 4'h1;
              end
            end
          end
        end
        default: tst_q <= T_IDLE;
      endcase
    end
  end

  assign frame_end   = (rst_q == R_DATA) & tick_q & (rtick_q == `SPBFC_OVS_LAST) &
                       (rbits_q == 4'h1);
  // Before the stop sample shifts in, the data bits sit in 9:1 (8:1 when eight-bit)
  assign rx_word     = nine_bit ? rsh_q[9:1] : {1'b0, rsh_q[8:1]};
  assign rx_is_break = (rsh_q[9:1] == 9'h000);
  assign idle_hit    = (hi_cnt_q == (nine_bit ? 8'hB0 : 8'hA0)) & idle_armed_q;

  // Receiver: centre on start bit, then sample every sixteen ticks
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rst_q   <= R_IDLE;
      rsh_q   <= 10'h000;
      rbits_q <= 4'h0;
      rtick_q <= 4'h0;
    end
    else if (!ctrl_two_q[`SPBFC_C2_RX_ON])
      rst_q <= R_IDLE;
    else if (tick_q)
    begin
      case (rst_q)
        R_IDLE:
          if (!rx_line)
          begin
            rtick_q <= 4'h0;
            rst_q   <= R_STRT;
          end
        R_STRT:
        begin
          rtick_q <= rtick_q + 4'h1;
          if (rtick_q == `SPBFC_OVS_MID)
          begin
            // A glitch shorter than half a bit is not a start
            rst_q   <= rx_line ? R_IDLE : R_DATA;
            rtick_q <= 4'h0;
            rbits_q <= nbits;
          end
        end
        R_DATA:
        begin
          rtick_q <= rtick_q + 4'h1;
          if (rtick_q == `SPBFC_OVS_LAST)
          begin
            rsh_q   <= nine_bit ? {rx_line, rsh_q[9:1]} : {1'b0, rx_line, rsh_q[8:1]};
            rbits_q <= rbits_q - 4'h1;
            if (rbits_q == 4'h1)
              rst_q <= R_IDLE;
          end
        end
        default: rst_q <= R_IDLE;
      endcase
    end
  end

  // Received word, errors and status flags; a set beats a clear
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rx_data_q         <= 9'h000;
      rx_full_q         <= 1'b0;
      rx_par_err_q      <= 1'b0;
      rx_frame_err_q    <= 1'b0;
      break_seen_flag_q <= 1'b0;
      edge_seen_flag_q  <= 1'b0;
      idle_flag_q       <= 1'b0;
      line_prev_q       <= 1'b1;
      hi_cnt_q          <= 8'h00;
      idle_armed_q      <= 1'b0;
    end
    else
    begin
      line_prev_q <= rx_line;
      if (line_prev_q & ~rx_line)
        edge_seen_flag_q <= 1'b1;
      else if (flag_clr[1])
        edge_seen_flag_q <= 1'b0;
      if (frame_end && rx_is_break && !rx_line)
        break_seen_flag_q <= 1'b1;
      else if (flag_clr[0])
        break_seen_flag_q <= 1'b0;
      if (idle_hit)
        idle_flag_q <= 1'b1;
      else if (flag_clr[2])
        idle_flag_q <= 1'b0;
      // Standby (wakeup bit set) suppresses delivery until software clears the bit
      if (frame_end && !ctrl_two_q[`SPBFC_C2_WAKEUP])
      begin
        rx_data_q      <= rx_word;
        rx_full_q      <= 1'b1;
        rx_frame_err_q <= ~rx_line;
        rx_par_err_q   <= ctrl_one_q[`SPBFC_C1_PAR_EN] &
                          ((nine_bit ? ^rsh_q[9:1] : ^rsh_q[8:1]) ^ ctrl_one_q[`SPBFC_C1_PAR_ODD]);
      end
      else if (rx_take)
        rx_full_q <= 1'b0;
      // High time in ticks; restarted by a low, or by the stop when selected
      if (!rx_line || (frame_end && ctrl_one_q[`SPBFC_C1_ILT]))
        hi_cnt_q <= 8'h00;
      else if (tick_q && hi_cnt_q != 8'hFF)
        hi_cnt_q <= hi_cnt_q + 8'h01;
      if (!rx_line)
        idle_armed_q <= 1'b1;
      else if (idle_hit)
        idle_armed_q <= 1'b0;
    end
  end

  // One interrupt request from every enabled source
  always @(posedge mclk)
  begin
    if (!rst_n)
      irq_q <= 1'b0;
    else
      irq_q <= (break_seen_flag_q & div_high_q[`SPBFC_DH_BREAK_IRQ]) |
               (edge_seen_flag_q & div_high_q[`SPBFC_DH_EDGE_IRQ]) |
               (rx_full_q & ctrl_two_q[`SPBFC_C2_RXF_IRQ]) |
               (idle_flag_q & ctrl_two_q[`SPBFC_C2_IDLE_IRQ]) |
               (~fifo_valid & ctrl_two_q[`SPBFC_C2_TXE_IRQ]) |
               (~fifo_valid & (tst_q == T_IDLE) & ctrl_two_q[`SPBFC_C2_TXD_IRQ]);
  end
endmodule // spbfc_top

`default_nettype wire

// File: tb/spbfc_top_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module spbfc_top_asserts
(
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_q,
  input wire logic       rx_full_q,
  input wire logic       break_seen_flag_q,
  input wire logic       edge_seen_flag_q,
  input wire logic       irq_q,
  input wire logic       txd_o_q,
  input wire logic       txd_oe_n_q
);
  logic [5:0]  en_q;
  logic [15:0] low_cnt_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Shadow of every interrupt enable, so irq can be traced to a cause
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      en_q <= 6'h00;
    else if (reg_wr && reg_addr == 8'h18)
      en_q[5:4] <= reg_wdata[7:6];
    else if (reg_wr && reg_addr == 8'h1B)
      en_q[3:0] <= reg_wdata[7:4];
  end
  // Length of the current low run on the transmit pin
  always_ff @(posedge mclk)
  begin
    if (!rst_n || txd_o_q)
      low_cnt_q <= 16'h0000;
    else
      low_cnt_q <= low_cnt_q + 16'h0001;
  end
  a_unmapped_read_zero: assert property (
    reg_rd && (reg_addr < 8'h18 || reg_addr > 8'h1B) |=> reg_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl_one_holes: assert property (
    reg_rd && reg_addr == 8'h1A |=> (reg_rdata_q & 8'h48) == 8'h00)
    else $error("control one unused bits set");
  a_div_high_hole: assert property (
    reg_rd && reg_addr == 8'h18 |=> !reg_rdata_q[5])
    else $error("divisor high bit 5 set");
  a_ctrl_two_back: assert property (
    reg_wr && reg_addr == 8'h1B ##1 !reg_wr ##1 reg_rd && !reg_wr && reg_addr == 8'h1B
    |=> reg_rdata_q == $past(reg_wdata, 3)) else $error("control two readback differs");
  a_rdata_holds: assert property (
    !reg_rd |=> $stable(reg_rdata_q)) else $error("read data moved without read");
  a_irq_break: assert property (
    break_seen_flag_q && en_q[5] |=> irq_q) else $error("break irq missing");
  a_irq_edge: assert property (
    edge_seen_flag_q && en_q[4] |=> irq_q) else $error("edge irq missing");
  a_irq_has_cause: assert property (
    irq_q |-> $past(|en_q)) else $error("irq with all enables off");
  a_idle_line_high: assert property (
    txd_oe_n_q |-> txd_o_q) else $error("released pin not high");
  a_bit_time_whole: assert property (
    $rose(txd_o_q) |-> low_cnt_q[5:0] == 6'h00) else $error("low run not whole bits");
  c_irq: cover property (irq_q);
  c_rx_word: cover property ($rose(rx_full_q));
  c_tx_start: cover property ($fell(txd_o_q));
endmodule // spbfc_top_asserts
bind spbfc_top spbfc_top_asserts spbfc_top_asserts_inst (.mclk, .rst_n, .reg_addr, .reg_wr,
  .reg_rd, .reg_wdata, .reg_rdata_q, .rx_full_q, .break_seen_flag_q, .edge_seen_flag_q,
  .irq_q, .txd_o_q, .txd_oe_n_q);
`default_nettype wire

// File: tb/spbfc_node.sv
`timescale 1ns/100ps
`default_nettype none
module spbfc_node
#(
  parameter int BIT_CYC = 64
)
(
  input  wire logic mclk,
  input  wire logic txd,
  input  wire logic nine,
  output var  logic rxd
);
  logic [9:0] got[$];
  logic [9:0] w;
  // Recessive line idles high
  initial rxd = 1'b1;
  // Frame bits LSB first, start bit in bit 0
  task automatic send(input logic [10:0] bits, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge mclk);
      rxd <= bits[i];
      repeat (BIT_CYC - 1) @(posedge mclk);
    end
    @(posedge mclk);
    rxd <= 1'b1;
  endtask
  task automatic hold(input logic v);
    @(posedge mclk);
    rxd <= v;
  endtask
  // Sample at bit centres, far from the design's edges; data then stop
  always
  begin
    @(negedge txd);
    repeat (BIT_CYC / 2) @(posedge mclk);
    w = 10'h000;
    for (int i = 0; i < (nine ? 10 : 9); i++)
    begin
      repeat (BIT_CYC) @(posedge mclk);
      w[i] = txd;
    end
    got.push_back(w);
  end
endmodule // spbfc_node
`default_nettype wire

// File: tb/spbfc_bench.sv
`timescale 1ns/100ps
`default_nettype none
module spbfc_bench;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [8:0] tx_data = 9'h000;
  logic       tx_valid = 1'b0;
  logic       rx_take = 1'b0;
  logic [2:0] flag_clr = 3'h0;
  logic       nine = 1'b0;
  wire  [7:0] reg_rdata_q;
  wire  [8:0] rx_data_q;
  wire        tx_ready, rx_full_q, rx_par_err_q, break_seen_flag_q, edge_seen_flag_q;
  wire        irq_q, rxd, txd_o_q, txd_oe_n_q, rx_frame_err_q, idle_flag_q;
  // Pull-up holds the transmit line high when released
  wire        txd_line = txd_oe_n_q ? 1'b1 : txd_o_q;
  int         err_count = 0;
  int         num_checks = 0;
  logic [26:0] tx_tab[3] = '{{8'h02, 9'h007, 10'h187}, {8'h13, 9'h0A5, 10'h3A5},
                             {8'h12, 9'h1A5, 10'h2A5}};
  logic [32:0] rx_tab[3] = '{{8'h00, 11'h34A, 4'hA, 9'h0A5, 1'b0},
                             {8'h13, 11'h54A, 4'hB, 9'h0A5, 1'b1},
                             {8'h13, 11'h74A, 4'hB, 9'h1A5, 1'b0}};
  always #12.5 mclk = ~mclk;
  spbfc_top spbfc_top_inst (.mclk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata_q, .tx_data, .tx_valid, .tx_ready, .rx_data_q, .rx_full_q, .rx_par_err_q,
    .rx_frame_err_q, .rx_take, .flag_clr, .break_seen_flag_q, .edge_seen_flag_q,
    .idle_flag_q, .irq_q, .rxd_i(rxd), .txd_i(txd_line), .txd_o_q, .txd_oe_n_q);
  // Divisor 1 gives 64 clocks per bit
  spbfc_node spbfc_node_inst (.mclk(mclk), .txd(txd_line), .nine(nine), .rxd(rxd));
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a; // Offset inside the port window
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Read data is registered, so look just after the taking edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk({2'b00, reg_rdata_q}, {2'b00, e});
  endtask
  task automatic push(input logic [8:0] d);
    @(posedge mclk);
    tx_data <= d;
    tx_valid <= 1'b1;
    do @(negedge mclk); while (tx_ready !== 1'b1);
    @(posedge mclk);
    tx_valid <= 1'b0;
  endtask
  task automatic strobe(input logic t, input logic [2:0] m);
    @(posedge mclk);
    rx_take <= t;
    flag_clr <= m;
    @(posedge mclk);
    rx_take <= 1'b0;
    flag_clr <= 3'h0;
  endtask
  task automatic rx_chk(input logic [8:0] d, input logic pe);
    int n = 0;
    while (rx_full_q !== 1'b1 && n < 2000)
    begin
      @(negedge mclk);
      n++;
    end
    chk({rx_par_err_q, rx_full_q, rx_data_q[7:0]}, {pe, 1'b1, d[7:0]});
    chk({9'h000, rx_data_q[8]}, {9'h000, d[8]});
    strobe(1'b1, 3'h0);
  endtask
  // Mode changes wait out the stop bit of the frame just captured
  task automatic tx_chk(input logic [9:0] e);
    int n = 0;
    while (spbfc_node_inst.got.size() == 0 && n < 1000)
    begin
      @(negedge mclk);
      n++;
    end
    chk(spbfc_node_inst.got.size() ? spbfc_node_inst.got.pop_front() : 10'h3FF, e);
    repeat (40) @(posedge mclk);
  endtask
  initial
  begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    // Reset values and an unmapped offset
    rd(8'h18, 8'h00);
    rd(8'h19, 8'h04);
    rd(8'h1A, 8'h00);
    rd(8'h1B, 8'h00);
    rd(8'h1C, 8'h00);
    wr(8'h1A, 8'hFF);
    rd(8'h1A, 8'hB7);
    // High half stays buffered until the low half is written
    wr(8'h18, 8'hFF);
    rd(8'h18, 8'hC0);
    wr(8'h19, 8'h01);
    rd(8'h18, 8'hDF);
    wr(8'h18, 8'h00);
    wr(8'h19, 8'h01);
    rd(8'h19, 8'h01);
    wr(8'h1A, 8'h00);
    wr(8'h1B, 8'hF0);
    rd(8'h1B, 8'hF0);
    wr(8'h1B, 8'h00);
    // Fill the queue with the transmitter off, then drain it
    for (int i = 0; i < 8; i++)
      push(9'h0C1 + i[8:0]);
    @(negedge mclk);
    chk({9'h000, tx_ready}, 10'h000);
    wr(8'h1B, 8'h08);
    for (int i = 0; i < 8; i++)
      tx_chk(10'h1C1 + i[9:0]);
    foreach (tx_tab[k])
    begin
      wr(8'h1A, tx_tab[k][26:19]);
      nine <= tx_tab[k][23];
      push(tx_tab[k][18:10]);
      tx_chk(tx_tab[k][9:0]);
    end
    // Receive on the pin in both lengths, one parity fault
    wr(8'h1B, 8'h0C);
    foreach (rx_tab[k])
    begin
      wr(8'h1A, rx_tab[k][32:25]);
      spbfc_node_inst.send(rx_tab[k][24:14], int'(rx_tab[k][13:10]));
      rx_chk(rx_tab[k][9:1], rx_tab[k][0]);
    end
    // Break frame: flags set, irq only once enabled
    wr(8'h1A, 8'h00);
    spbfc_node_inst.send(11'h000, 10);
    @(negedge mclk);
    chk({6'h00, rx_frame_err_q, idle_flag_q, break_seen_flag_q, irq_q}, 10'h00A);
    wr(8'h18, 8'h80);
    repeat (2) @(negedge mclk);
    chk({8'h00, edge_seen_flag_q, irq_q}, 10'h003);
    wr(8'h18, 8'h40);
    strobe(1'b1, 3'h1);
    repeat (2) @(negedge mclk);
    chk({7'h00, break_seen_flag_q, edge_seen_flag_q, irq_q}, 10'h003);
    strobe(1'b0, 3'h2);
    repeat (2) @(negedge mclk);
    chk({8'h00, edge_seen_flag_q, irq_q}, 10'h000);
    // Over ten bit times of high line after the break raise idle; clear drops it
    repeat (700) @(negedge mclk);
    chk({9'h000, idle_flag_q}, 10'h001);
    strobe(1'b0, 3'h4);
    @(negedge mclk);
    chk({9'h000, idle_flag_q}, 10'h000);
    // Loop modes must ignore the receive pin, held low here
    wr(8'h18, 8'h00);
    for (int s = 0; s < 2; s++)
    begin
      wr(8'h1A, s ? 8'hA0 : 8'h80);
      spbfc_node_inst.hold(1'b0);
      push(9'h03C + s[8:0]);
      rx_chk(9'h03C + s[8:0], 1'b0);
    end
    test_done();
  end
  // Watchdog, far beyond the expected run length
  initial
  begin
    #1000000;
    err_count++;
    test_done();
  end
endmodule // spbfc_bench
`default_nettype wire
